// file: iormap_io_regs.sv
// io register space: register cells, bit access, read and skip answers
`timescale 1ns/1ps
module iormap_io_regs (
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_reset_n,
    // core io access
    input  wire logic [5:0]            i_io_addr,
    input  wire logic                  i_io_wr,
    input  wire logic [7:0]            i_io_wdata,
    input  wire logic                  i_io_rd,
    // single-bit operations
    input  iormap_pkg::iormap_bit_op_t i_bit_op,
    input  wire logic [2:0]            i_bit_sel,
    // hardware values
    input  wire logic [7:0]            i_conv_result_low,
    input  wire logic [7:0]            i_conv_result_high,
    input  wire logic [7:0]            i_serial_buffer,
    input  wire logic [5:0]            i_port_pins,
    input  wire logic                  i_comp_out,
    input  wire logic                  i_serial_collision,
    input  wire logic                  i_pll_locked,
    // hardware flag events, one-cycle pulses
    input  wire logic                  i_conv_done,
    input  wire logic                  i_comp_event,
    input  wire logic [2:0]            i_serial_flag_set,
    input  wire logic [5:0]            i_timer_flag_set,
    input  wire logic [1:0]            i_ext_flag_set,
    // core answers
    output logic [7:0]                 o_io_rdata,
    output logic                       o_io_rdata_valid,
    output logic                       o_skip_valid,
    output logic                       o_skip_taken,
    output logic                       o_access_refused,
    // converter and comparator
    output logic [7:0]                 o_converter_control_b,
    output logic [7:0]                 o_converter_control_status_a,
    output logic [7:0]                 o_converter_input_select,
    output logic [7:0]                 o_comparator_control_status,
    // serial unit
    output logic [7:0]                 o_serial_unit_control,
    output logic [7:0]                 o_serial_unit_status,
    output logic [7:0]                 o_serial_unit_shift_data,
    // scratch and port
    output logic [7:0]                 o_scratch_byte_0,
    output logic [7:0]                 o_scratch_byte_1,
    output logic [7:0]                 o_scratch_byte_2,
    output logic [7:0]                 o_digital_input_disable,
    output logic [7:0]                 o_pin_change_mask,
    output logic [7:0]                 o_port_direction,
    output logic [7:0]                 o_port_output_latch,
    output logic [7:0]                 o_eeprom_control,
    // clocking
    output logic [7:0]                 o_deadtime_channel_a,
    output logic [7:0]                 o_clock_prescale,
    output logic [7:0]                 o_pll_control_status,
    output logic [7:0]                 o_oscillator_trim,
    // timers
    output logic [7:0]                 o_timer_zero_compare_b,
    output logic [7:0]                 o_timer_zero_compare_a,
    output logic [7:0]                 o_timer_zero_control_a,
    output logic [7:0]                 o_timer_zero_control_b,
    output logic [7:0]                 o_timer_zero_count,
    output logic [7:0]                 o_timer_one_compare_a,
    output logic [7:0]                 o_timer_one_compare_b,
    output logic [7:0]                 o_timer_one_compare_c,
    output logic [7:0]                 o_timer_one_count,
    output logic [7:0]                 o_timer_one_control,
    output logic [7:0]                 o_general_timer_control,
    // interrupts and core
    output logic [7:0]                 o_timer_interrupt_flags,
    output logic [7:0]                 o_timer_interrupt_mask,
    output logic [7:0]                 o_external_interrupt_flags,
    output logic [7:0]                 o_external_interrupt_mask,
    output logic [7:0]                 o_reset_cause_status,
    output logic [7:0]                 o_core_control,
    output logic [7:0]                 o_self_program_control,
    output logic [7:0]                 o_stack_pointer_low,
    output logic [7:0]                 o_stack_pointer_high,
    output logic [7:0]                 o_processor_status_flags
);
    typedef struct packed {
        logic [7:0] rdata;
        logic       rdata_valid;
        logic       skip_valid;
        logic       skip_taken;
        logic       refused;
    } iormap_top_t;

    iormap_top_t r;
    iormap_top_t next_r;

    logic       wr_en;
    logic [7:0] wr_bits;
    logic [7:0] wr_data;
    logic       skip_req;
    logic       refused;
    logic [7:0] stored  [iormap_pkg::NUM_REGS];
    logic [7:0] readv   [iormap_pkg::NUM_REGS];
    logic [7:0] hw_set  [iormap_pkg::NUM_REGS];
    logic [7:0] hw_val  [iormap_pkg::NUM_REGS];
    logic       sel_bit;

    // request decode
    iormap_bit_decode u_decode (
        .i_io_wr    (i_io_wr),
        .i_io_addr  (i_io_addr),
        .i_io_wdata (i_io_wdata),
        .i_bit_op   (i_bit_op),
        .i_bit_sel  (i_bit_sel),
        .o_wr_en    (wr_en),
        .o_wr_bits  (wr_bits),
        .o_wr_data  (wr_data),
        .o_skip_req (skip_req),
        .o_refused  (refused)
    );

    // hardware values and flag events routed to their registers
    always_comb begin
        for (int k = 0; k < iormap_pkg::NUM_REGS; k++) begin
            hw_set[k] = 8'h00;
            hw_val[k] = 8'h00;
        end
        hw_val[iormap_pkg::ADR_CONV_RES_LO] = i_conv_result_low;
        hw_val[iormap_pkg::ADR_CONV_RES_HI] = i_conv_result_high;
        hw_val[iormap_pkg::ADR_SER_BUF]     = i_serial_buffer;
        hw_val[iormap_pkg::ADR_PORT_PINS]   = {2'b00, i_port_pins};
        hw_val[iormap_pkg::ADR_COMP_CTRL][iormap_pkg::POS_COMP_OUT] = i_comp_out;
        hw_val[iormap_pkg::ADR_SER_STATUS][iormap_pkg::POS_SER_COLL] = i_serial_collision;
        hw_val[iormap_pkg::ADR_PLL_CTRL][iormap_pkg::POS_PLL_LOCK] = i_pll_locked;
        hw_set[iormap_pkg::ADR_CONV_CTRL_A][iormap_pkg::POS_CONV_DONE] = i_conv_done;
        hw_set[iormap_pkg::ADR_COMP_CTRL][iormap_pkg::POS_COMP_EVENT] = i_comp_event;
        hw_set[iormap_pkg::ADR_SER_STATUS][iormap_pkg::POS_SER_FLAGS +: 3] = i_serial_flag_set;
        hw_set[iormap_pkg::ADR_TIMER_FLAGS][iormap_pkg::POS_TIMER_FLAGS +: 6] = i_timer_flag_set;
        hw_set[iormap_pkg::ADR_EXT_FLAGS][iormap_pkg::POS_EXT_FLAGS +: 2] = i_ext_flag_set;
    end

    // one cell per io address; reserved addresses get empty masks
    for (genvar g = 0; g < iormap_pkg::NUM_REGS; g++) begin : g_cell
        localparam iormap_pkg::iormap_mask_t M = iormap_pkg::iormap_reg_mask(6'(g));
        iormap_reg_cell #(
            .WR_MASK     (M.wr),
            .W1C_MASK    (M.w1c),
            .HW_MASK     (M.hw),
            .RESET_VALUE (iormap_pkg::RESET_VALUE)
        ) u_cell (
            .i_clk      (i_clk),
            .i_reset_n  (i_reset_n),
            .i_wr_en    (wr_en && (i_io_addr == 6'(g))),
            .i_wr_bits  (wr_bits),
            .i_wr_data  (wr_data),
            .i_hw_set   (hw_set[g]),
            .i_hw_value (hw_val[g]),
            .o_stored   (stored[g]),
            .o_read     (readv[g])
        );
    end

    // read data and skip answers, registered
    always_comb begin
        sel_bit            = readv[i_io_addr][i_bit_sel];
        next_r             = r;
        next_r.rdata_valid = i_io_rd;
        next_r.skip_valid  = skip_req;
        next_r.refused     = refused;
        if (i_io_rd) begin
            next_r.rdata = readv[i_io_addr];
        end
        if (skip_req) begin
            next_r.skip_taken = (i_bit_op == iormap_pkg::SKIP_IF_IO_BIT_SET_OP) ?
                                sel_bit : !sel_bit;
        end else begin
            next_r.skip_taken = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // core answers
    assign o_io_rdata       = r.rdata;
    assign o_io_rdata_valid = r.rdata_valid;
    assign o_skip_valid     = r.skip_valid;
    assign o_skip_taken     = r.skip_taken;
    assign o_access_refused = r.refused;

    // register contents, straight from the cell flip-flops
    assign o_converter_control_b        = stored[iormap_pkg::ADR_CONV_CTRL_B];
    assign o_converter_control_status_a = stored[iormap_pkg::ADR_CONV_CTRL_A];
    assign o_converter_input_select     = stored[iormap_pkg::ADR_CONV_INSEL];
    assign o_comparator_control_status  = stored[iormap_pkg::ADR_COMP_CTRL];
    assign o_serial_unit_control        = stored[iormap_pkg::ADR_SER_CTRL];
    assign o_serial_unit_status         = stored[iormap_pkg::ADR_SER_STATUS];
    assign o_serial_unit_shift_data     = stored[iormap_pkg::ADR_SER_SHIFT];
    assign o_scratch_byte_0             = stored[iormap_pkg::ADR_SCRATCH0];
    assign o_scratch_byte_1             = stored[iormap_pkg::ADR_SCRATCH1];
    assign o_scratch_byte_2             = stored[iormap_pkg::ADR_SCRATCH2];
    assign o_digital_input_disable      = stored[iormap_pkg::ADR_DIG_IN_DIS];
    assign o_pin_change_mask            = stored[iormap_pkg::ADR_PIN_CHG_MASK];
    assign o_port_direction             = stored[iormap_pkg::ADR_PORT_DIR];
    assign o_port_output_latch          = stored[iormap_pkg::ADR_PORT_LATCH];
    assign o_eeprom_control             = stored[iormap_pkg::ADR_EEP_CTRL];
    assign o_deadtime_channel_a         = stored[iormap_pkg::ADR_DEADTIME_A];
    assign o_clock_prescale             = stored[iormap_pkg::ADR_CLK_PRESCALE];
    assign o_pll_control_status         = stored[iormap_pkg::ADR_PLL_CTRL];
    assign o_oscillator_trim            = stored[iormap_pkg::ADR_OSC_TRIM];
    assign o_timer_zero_compare_b       = stored[iormap_pkg::ADR_T0_CMP_B];
    assign o_timer_zero_compare_a       = stored[iormap_pkg::ADR_T0_CMP_A];
    assign o_timer_zero_control_a       = stored[iormap_pkg::ADR_T0_CTRL_A];
    assign o_timer_zero_control_b       = stored[iormap_pkg::ADR_T0_CTRL_B];
    assign o_timer_zero_count           = stored[iormap_pkg::ADR_T0_COUNT];
    assign o_timer_one_compare_a        = stored[iormap_pkg::ADR_T1_CMP_A];
    assign o_timer_one_compare_b        = stored[iormap_pkg::ADR_T1_CMP_B];
    assign o_timer_one_compare_c        = stored[iormap_pkg::ADR_T1_CMP_C];
    assign o_timer_one_count            = stored[iormap_pkg::ADR_T1_COUNT];
    assign o_timer_one_control          = stored[iormap_pkg::ADR_T1_CTRL];
    assign o_general_timer_control      = stored[iormap_pkg::ADR_GEN_TIMER];
    assign o_timer_interrupt_flags      = stored[iormap_pkg::ADR_TIMER_FLAGS];
    assign o_timer_interrupt_mask       = stored[iormap_pkg::ADR_TIMER_MASK];
    assign o_external_interrupt_flags   = stored[iormap_pkg::ADR_EXT_FLAGS];
    assign o_external_interrupt_mask    = stored[iormap_pkg::ADR_EXT_MASK];
    assign o_reset_cause_status         = stored[iormap_pkg::ADR_RESET_CAUSE];
    assign o_core_control               = stored[iormap_pkg::ADR_CORE_CTRL];
    assign o_self_program_control       = stored[iormap_pkg::ADR_SELF_PROG];
    assign o_stack_pointer_low          = stored[iormap_pkg::ADR_STACK_LO];
    assign o_stack_pointer_high         = stored[iormap_pkg::ADR_STACK_HI];
    assign o_processor_status_flags     = stored[iormap_pkg::ADR_STATUS_FLAGS];
endmodule

// file: iormap_pkg.sv
// package: io register offsets, bit masks, field positions and access codes
package iormap_pkg;
    localparam int unsigned ADDR_W   = 6;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned NUM_REGS = 64;
    localparam logic [5:0] BIT_ACCESS_LAST = 6'h1F;
    localparam logic [7:0] RESET_VALUE     = 8'h00;
    localparam logic [7:0] ALL_BITS        = 8'hFF;
    localparam logic [7:0] ONE_BIT         = 8'h01;

    // register offsets
    localparam logic [5:0] ADR_CONV_CTRL_B   = 6'h03;
    localparam logic [5:0] ADR_CONV_RES_LO   = 6'h04;
    localparam logic [5:0] ADR_CONV_RES_HI   = 6'h05;
    localparam logic [5:0] ADR_CONV_CTRL_A   = 6'h06;
    localparam logic [5:0] ADR_CONV_INSEL    = 6'h07;
    localparam logic [5:0] ADR_COMP_CTRL     = 6'h08;
    localparam logic [5:0] ADR_SER_CTRL      = 6'h0D;
    localparam logic [5:0] ADR_SER_STATUS    = 6'h0E;
    localparam logic [5:0] ADR_SER_SHIFT     = 6'h0F;
    localparam logic [5:0] ADR_SER_BUF       = 6'h10;
    localparam logic [5:0] ADR_SCRATCH0      = 6'h11;
    localparam logic [5:0] ADR_SCRATCH1      = 6'h12;
    localparam logic [5:0] ADR_SCRATCH2      = 6'h13;
    localparam logic [5:0] ADR_DIG_IN_DIS    = 6'h14;
    localparam logic [5:0] ADR_PIN_CHG_MASK  = 6'h15;
    localparam logic [5:0] ADR_PORT_PINS     = 6'h16;
    localparam logic [5:0] ADR_PORT_DIR      = 6'h17;
    localparam logic [5:0] ADR_PORT_LATCH    = 6'h18;
    localparam logic [5:0] ADR_EEP_CTRL      = 6'h1C;
    localparam logic [5:0] ADR_DEADTIME_A    = 6'h25;
    localparam logic [5:0] ADR_CLK_PRESCALE  = 6'h26;
    localparam logic [5:0] ADR_PLL_CTRL      = 6'h27;
    localparam logic [5:0] ADR_T0_CMP_B      = 6'h28;
    localparam logic [5:0] ADR_T0_CMP_A      = 6'h29;
    localparam logic [5:0] ADR_T0_CTRL_A     = 6'h2A;
    localparam logic [5:0] ADR_T1_CMP_B      = 6'h2B;
    localparam logic [5:0] ADR_GEN_TIMER     = 6'h2C;
    localparam logic [5:0] ADR_T1_CMP_C      = 6'h2D;
    localparam logic [5:0] ADR_T1_CMP_A      = 6'h2E;
    localparam logic [5:0] ADR_T1_COUNT      = 6'h2F;
    localparam logic [5:0] ADR_T1_CTRL       = 6'h30;
    localparam logic [5:0] ADR_OSC_TRIM      = 6'h31;
    localparam logic [5:0] ADR_T0_COUNT      = 6'h32;
    localparam logic [5:0] ADR_T0_CTRL_B     = 6'h33;
    localparam logic [5:0] ADR_RESET_CAUSE   = 6'h34;
    localparam logic [5:0] ADR_CORE_CTRL     = 6'h35;
    localparam logic [5:0] ADR_SELF_PROG     = 6'h37;
    localparam logic [5:0] ADR_TIMER_FLAGS   = 6'h38;
    localparam logic [5:0] ADR_TIMER_MASK    = 6'h39;
    localparam logic [5:0] ADR_EXT_FLAGS     = 6'h3A;
    localparam logic [5:0] ADR_EXT_MASK      = 6'h3B;
    localparam logic [5:0] ADR_STACK_LO      = 6'h3D;
    localparam logic [5:0] ADR_STACK_HI      = 6'h3E;
    localparam logic [5:0] ADR_STATUS_FLAGS  = 6'h3F;

    // field positions of hardware-owned bits
    localparam int unsigned POS_CONV_DONE   = 4;
    localparam int unsigned POS_COMP_EVENT  = 4;
    localparam int unsigned POS_COMP_OUT    = 5;
    localparam int unsigned POS_SER_FLAGS   = 5;
    localparam int unsigned POS_SER_COLL    = 4;
    localparam int unsigned POS_PLL_LOCK    = 0;
    localparam int unsigned POS_TIMER_FLAGS = 1;
    localparam int unsigned POS_EXT_FLAGS   = 5;

    typedef enum logic [2:0] {
        NO_IO_BIT_OP,
        SET_IO_BIT_OP,
        CLEAR_IO_BIT_OP,
        SKIP_IF_IO_BIT_SET_OP,
        SKIP_IF_IO_BIT_CLEAR_OP
    } iormap_bit_op_t;

    // wr: software written, w1c: cleared by writing one, hw: read from hardware
    typedef struct packed {
        logic [7:0] wr;
        logic [7:0] w1c;
        logic [7:0] hw;
    } iormap_mask_t;

    function automatic iormap_mask_t iormap_reg_mask(input logic [5:0] a);
        iormap_mask_t m;
        m = '{8'h00, 8'h00, 8'h00};
        case (a)
            ADR_CONV_CTRL_B:  m = '{8'hE7, 8'h00, 8'h00};
            ADR_CONV_RES_LO,
            ADR_CONV_RES_HI,
            ADR_SER_BUF:      m = '{8'h00, 8'h00, 8'hFF};
            ADR_CONV_CTRL_A:  m = '{8'hEF, 8'h10, 8'h00};
            ADR_COMP_CTRL:    m = '{8'hCB, 8'h10, 8'h20};
            ADR_SER_STATUS:   m = '{8'h0F, 8'hE0, 8'h10};
            ADR_DIG_IN_DIS,
            ADR_PIN_CHG_MASK,
            ADR_PORT_DIR,
            ADR_PORT_LATCH,
            ADR_EEP_CTRL,
            ADR_SELF_PROG:    m = '{8'h3F, 8'h00, 8'h00};
            ADR_PORT_PINS:    m = '{8'h00, 8'h00, 8'h3F};
            ADR_CLK_PRESCALE: m = '{8'h8F, 8'h00, 8'h00};
            ADR_PLL_CTRL:     m = '{8'h86, 8'h00, 8'h01};
            ADR_T0_CTRL_A:    m = '{8'hF3, 8'h00, 8'h00};
            ADR_T0_CTRL_B:    m = '{8'hCF, 8'h00, 8'h00};
            ADR_RESET_CAUSE:  m = '{8'h0F, 8'h00, 8'h00};
            ADR_TIMER_FLAGS:  m = '{8'h00, 8'h7E, 8'h00};
            ADR_TIMER_MASK:   m = '{8'h7E, 8'h00, 8'h00};
            ADR_EXT_FLAGS:    m = '{8'h00, 8'h60, 8'h00};
            ADR_EXT_MASK:     m = '{8'h60, 8'h00, 8'h00};
            ADR_STACK_HI:     m = '{8'h03, 8'h00, 8'h00};
            ADR_SER_CTRL, ADR_SER_SHIFT, ADR_SCRATCH0, ADR_SCRATCH1,
            ADR_SCRATCH2, ADR_CONV_INSEL, ADR_DEADTIME_A, ADR_T0_CMP_B,
            ADR_T0_CMP_A, ADR_T1_CMP_B, ADR_GEN_TIMER, ADR_T1_CMP_C,
            ADR_T1_CMP_A, ADR_T1_COUNT, ADR_T1_CTRL, ADR_OSC_TRIM,
            ADR_T0_COUNT, ADR_CORE_CTRL, ADR_STACK_LO,
            ADR_STATUS_FLAGS: m = '{8'hFF, 8'h00, 8'h00};
            default:          m = '{8'h00, 8'h00, 8'h00};
        endcase
        return m;
    endfunction
endpackage

// file: iormap_reg_cell.sv
// one io register: plain, write-one-to-clear and hardware-read bits
`timescale 1ns/1ps
module iormap_reg_cell #(
    parameter logic [7:0] WR_MASK     = 8'h00,
    parameter logic [7:0] W1C_MASK    = 8'h00,
    parameter logic [7:0] HW_MASK     = 8'h00,
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    // write request
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wr_bits,
    input  wire logic [7:0] i_wr_data,
    // hardware side
    input  wire logic [7:0] i_hw_set,
    input  wire logic [7:0] i_hw_value,
    // contents
    output logic [7:0]      o_stored,
    output logic [7:0]      o_read
);
    typedef struct packed {
        logic [7:0] value;
    } iormap_cell_t;

    iormap_cell_t r;
    iormap_cell_t next_r;
    logic [7:0]   hit;

    always_comb begin
        hit = i_wr_en ? i_wr_bits : 8'h00;
        // only addressed bits move; hardware set beats a same-cycle clear
        next_r.value = (((r.value & ~hit) | (i_wr_data & hit)) & WR_MASK)
                     | (((r.value & ~(hit & i_wr_data)) | i_hw_set) & W1C_MASK);
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            r.value <= RESET_VALUE & (WR_MASK | W1C_MASK);
        end else begin
            r <= next_r;
        end
    end

    assign o_stored = r.value;
    // reserved bits read as zero
    assign o_read = (r.value & (WR_MASK | W1C_MASK)) | (i_hw_value & HW_MASK);
endmodule

// file: iormap_bit_decode.sv
// turns a byte write or a single-bit operation into a register write or skip request
`timescale 1ns/1ps
module iormap_bit_decode (
    // core request
    input  wire logic                      i_io_wr,
    input  wire logic [5:0]                i_io_addr,
    input  wire logic [7:0]                i_io_wdata,
    input  iormap_pkg::iormap_bit_op_t     i_bit_op,
    input  wire logic [2:0]                i_bit_sel,
    // decoded request
    output logic                           o_wr_en,
    output logic [7:0]                     o_wr_bits,
    output logic [7:0]                     o_wr_data,
    output logic                           o_skip_req,
    output logic                           o_refused
);
    iormap_pkg::iormap_mask_t m;
    logic                     low;

    always_comb begin
        m          = iormap_pkg::iormap_reg_mask(i_io_addr);
        low        = (i_io_addr <= iormap_pkg::BIT_ACCESS_LAST);
        o_wr_en    = 1'b0;
        o_wr_bits  = iormap_pkg::ALL_BITS;
        o_wr_data  = i_io_wdata;
        o_skip_req = 1'b0;
        o_refused  = 1'b0;
        if (i_io_wr) begin
            // reserved address: no write, flagged
            o_wr_en   = (m != '0);
            o_refused = (m == '0);
        end else begin
            case (i_bit_op)
                iormap_pkg::SET_IO_BIT_OP,
                iormap_pkg::CLEAR_IO_BIT_OP: begin
                    o_wr_en   = low && (m != '0);
                    o_refused = !low || (m == '0);
                    o_wr_bits = 8'(iormap_pkg::ONE_BIT << i_bit_sel);
                    o_wr_data = (i_bit_op == iormap_pkg::SET_IO_BIT_OP) ?
                                iormap_pkg::ALL_BITS : 8'h00;
                end
                iormap_pkg::SKIP_IF_IO_BIT_SET_OP,
                iormap_pkg::SKIP_IF_IO_BIT_CLEAR_OP: begin
                    o_skip_req = low;
                    o_refused  = !low;
                end
                default: begin
                    o_wr_en = 1'b0;
                end
            endcase
        end
    end
endmodule

// file: iormap_io_monitor.sv
// checker for the io register space ports
`timescale 1ns/1ps
module iormap_io_monitor (
    // core request
    input wire logic       i_clk,
    input wire logic       i_reset_n,
    input wire logic [5:0] i_io_addr,
    input wire logic       i_io_wr,
    input wire logic [7:0] i_io_wdata,
    input iormap_pkg::iormap_bit_op_t i_bit_op,
    input wire logic [2:0] i_bit_sel,
    input wire logic [5:0] i_timer_flag_set,
    // answers
    input wire logic       o_skip_valid,
    input wire logic       o_access_refused,
    input wire logic [7:0] o_timer_interrupt_flags,
    input wire logic [7:0] o_scratch_byte_0
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    a_high_op_refused:
    assert property (!i_io_wr && i_bit_op != iormap_pkg::NO_IO_BIT_OP && i_io_addr > 6'h1F
        |=> o_access_refused && !o_skip_valid) else $error("high bit op taken");
    a_skip_answered:
    assert property (!i_io_wr && i_bit_op >= iormap_pkg::SKIP_IF_IO_BIT_SET_OP
        && i_io_addr <= 6'h1F |=> o_skip_valid) else $error("skip not answered");
    a_flag_one_clears:
    assert property (i_io_wr && i_io_addr == 6'h38 && i_timer_flag_set == 6'h00
        |=> o_timer_interrupt_flags == ($past(o_timer_interrupt_flags) & ~$past(i_io_wdata)))
        else $error("flag clear wrong");
    a_set_one_bit:
    assert property (!i_io_wr && i_io_addr == 6'h11 && i_bit_op == iormap_pkg::SET_IO_BIT_OP
        |=> o_scratch_byte_0 == ($past(o_scratch_byte_0) | (8'h01 << $past(i_bit_sel))))
        else $error("bit set touched others");
    a_reserved_refused:
    assert property (i_io_wr && (i_io_addr == 6'h36 || i_io_addr == 6'h3C) |=> o_access_refused)
        else $error("reserved write taken");
    c_skip: cover property (o_skip_valid);
    c_refused: cover property (o_access_refused);
    c_flags: cover property (o_timer_interrupt_flags != 8'h00);
endmodule
bind iormap_io_regs iormap_io_monitor i_iormap_io_monitor (.*);

// file: iormap_core_model.sv
// core side model: drives io requests toward the register space
`timescale 1ns/1ps
module iormap_core_model (
    // clock
    input wire logic    i_clk,
    // io request
    output logic [5:0]  o_addr,
    output logic        o_wr,
    output logic        o_rd,
    output logic [7:0]  o_wdata,
    output iormap_pkg::iormap_bit_op_t o_op,
    output logic [2:0]  o_sel
);
    initial begin
        o_op = iormap_pkg::NO_IO_BIT_OP;
        {o_wr, o_rd, o_addr, o_wdata, o_sel} = 19'h00000;
    end
    task automatic acc(input logic [5:0] a, input logic w, input logic r, input logic [7:0] d,
                       input iormap_pkg::iormap_bit_op_t o, input logic [2:0] s);
        @(posedge i_clk);
        #1;
        {o_addr, o_wr, o_rd, o_wdata} = {a, w, r, d};
        o_op = o;
        o_sel = s;
        @(posedge i_clk);
        #1;
        {o_wr, o_rd, o_wdata} = {2'h0, ~d};
        o_op = iormap_pkg::NO_IO_BIT_OP;
    endtask
endmodule

// file: io_register_space_map_tb_top.sv
// testbench: core model driving the io register space
`timescale 1ns/1ps
module io_register_space_map_tb_top;
    logic i_clk = 1'h0;
    logic i_reset_n = 1'h0;
    logic [7:0] hw = 8'h00;
    logic [5:0] tf = 6'h00;
    logic cd = 1'h0;
    logic [5:0] addr;
    logic wr, rd, skv, skt, refd, rvalid;
    logic [7:0] wdata, rdata, fl, sta, stack_pointer_low;
    logic [2:0] sel;
    iormap_pkg::iormap_bit_op_t bop;
    localparam iormap_pkg::iormap_bit_op_t NOP = iormap_pkg::NO_IO_BIT_OP;
    int failures = 0;
    int checks_done = 0;
    iormap_core_model i_iormap_core_model (.i_clk(i_clk), .o_addr(addr), .o_wr(wr), .o_rd(rd),
        .o_wdata(wdata), .o_op(bop), .o_sel(sel));
    iormap_io_regs i_iormap_io_regs (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_io_addr(addr),
        .i_io_wr(wr), .i_io_wdata(wdata), .i_io_rd(rd), .i_bit_op(bop), .i_bit_sel(sel),
        .i_conv_result_low(hw), .i_conv_result_high(hw), .i_serial_buffer(hw),
        .i_port_pins(hw[5:0]), .i_comp_out(hw[0]), .i_serial_collision(hw[1]),
        .i_pll_locked(hw[2]), .i_conv_done(cd), .i_comp_event(1'h0), .i_serial_flag_set(3'h0),
        .i_timer_flag_set(tf), .i_ext_flag_set(2'h0), .o_io_rdata(rdata),
        .o_io_rdata_valid(rvalid), .o_skip_valid(skv), .o_skip_taken(skt),
        .o_access_refused(refd), .o_converter_control_status_a(sta),
        .o_timer_interrupt_flags(fl), .o_stack_pointer_low(stack_pointer_low),
    .o_converter_control_b(), .o_converter_input_select(), .o_comparator_control_status(),
    .o_serial_unit_control(), .o_serial_unit_status(), .o_serial_unit_shift_data(),
    .o_scratch_byte_0(), .o_scratch_byte_1(), .o_scratch_byte_2(), .o_pin_change_mask(),
    .o_digital_input_disable(), .o_port_direction(), .o_port_output_latch(), .o_eeprom_control(),
    .o_deadtime_channel_a(), .o_clock_prescale(), .o_pll_control_status(), .o_oscillator_trim(),
    .o_timer_zero_compare_b(), .o_timer_zero_compare_a(), .o_timer_zero_control_a(),
    .o_timer_zero_control_b(), .o_timer_zero_count(), .o_timer_one_compare_a(),
    .o_timer_one_compare_b(), .o_timer_one_compare_c(), .o_timer_one_count(),
    .o_timer_one_control(), .o_general_timer_control(), .o_timer_interrupt_mask(),
    .o_external_interrupt_flags(), .o_external_interrupt_mask(), .o_core_control(),
    .o_reset_cause_status(), .o_self_program_control(), .o_stack_pointer_high(),
    .o_processor_status_flags());
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic io(input logic [5:0] a, input logic w, input logic r, input logic [7:0] d,
                      input iormap_pkg::iormap_bit_op_t o, input logic [2:0] s);
        i_iormap_core_model.acc(a, w, r, d, o, s);
    endtask
    task automatic t_flags;
        @(posedge i_clk);
        #1 tf = 6'h3F;
        @(posedge i_clk);
        #1 tf = 6'h00;
        chk({refd, fl}, 9'h07E);
        io(6'h38, 1'h1, 1'h0, 8'h0A, NOP, 3'h0);
        chk({refd, fl}, 9'h074);
        io(6'h38, 1'h1, 1'h0, 8'h00, NOP, 3'h0);
        chk({refd, fl}, 9'h074);
        io(6'h38, 1'h0, 1'h0, 8'h00, iormap_pkg::CLEAR_IO_BIT_OP, 3'h2);
        chk({refd, fl}, 9'h174);
    endtask
    task automatic t_bit_ops;
        io(6'h06, 1'h1, 1'h0, 8'h01, NOP, 3'h0);
        @(posedge i_clk);
        #1 cd = 1'h1;
        @(posedge i_clk);
        #1 cd = 1'h0;
        io(6'h06, 1'h0, 1'h0, 8'h00, iormap_pkg::SET_IO_BIT_OP, 3'h7);
        chk({refd, sta}, 9'h091);
        io(6'h06, 1'h0, 1'h0, 8'h00, iormap_pkg::CLEAR_IO_BIT_OP, 3'h0);
        chk({refd, sta}, 9'h090);
        io(6'h06, 1'h0, 1'h0, 8'h00, iormap_pkg::SKIP_IF_IO_BIT_SET_OP, 3'h4);
        chk({skv, 7'h00, skt}, 9'h101);
        io(6'h06, 1'h0, 1'h0, 8'h00, iormap_pkg::SKIP_IF_IO_BIT_CLEAR_OP, 3'h4);
        chk({skv, 7'h00, skt}, 9'h100);
        io(6'h11, 1'h0, 1'h0, 8'h00, iormap_pkg::SET_IO_BIT_OP, 3'h5);
    endtask
    task automatic t_reserved;
        io(6'h36, 1'h1, 1'h0, 8'hFF, NOP, 3'h0);
        chk({refd, 8'h00}, 9'h100);
        io(6'h36, 1'h0, 1'h1, 8'h00, NOP, 3'h0);
        chk({rvalid, rdata}, 9'h100);
        io(6'h3E, 1'h1, 1'h0, 8'hFF, NOP, 3'h0);
        io(6'h3E, 1'h0, 1'h1, 8'h00, NOP, 3'h0);
        chk({rvalid, rdata}, 9'h103);
        io(6'h3D, 1'h0, 1'h0, 8'h00, iormap_pkg::SET_IO_BIT_OP, 3'h0);
        chk({refd, stack_pointer_low}, 9'h100);
        hw = 8'hA5;
        io(6'h16, 1'h0, 1'h1, 8'h00, NOP, 3'h0);
        chk({rvalid, rdata}, 9'h125);
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        repeat (5) @(posedge i_clk);
        #1 i_reset_n = 1'h1;
        t_flags;
        t_bit_ops;
        t_reserved;
        report_and_stop;
    end
endmodule
